// *** sarc_clkdiv.v ***
/*
 Converter clock enable divider: a one-cycle pulse at pclk/1, /2, /8 or
 /16 from a two-bit divider code.
 Assumes it is held idle (run low) between conversions.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sarc_map.vh"

module sarc_clkdiv
(
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // Control
    input  wire       run,       // Count while high
    input  wire [1:0] div_code,  // Latched divider code
    // Output
    output wire       tick       // Converter clock enable
);

    // ------------------------------------------------------------------
    // Divide ratio decode
    // ------------------------------------------------------------------
    reg  [3:0] cnt_reg;          // Free counter inside a conversion
    reg  [3:0] last_val;         // Terminal count for the ratio

    // Ratio lookup
    always @*
    begin
        case (div_code)
            `SARC_DIV_CODE_16: last_val = 4'hF;
            `SARC_DIV_CODE_8:  last_val = 4'h7;
            `SARC_DIV_CODE_1:  last_val = 4'h0;
            default:           last_val = 4'h1;
        endcase
    end

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // Restarts each conversion so timing is exact from the start bit
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= 4'h0;
        else if (!run || cnt_reg == last_val)
            cnt_reg <= 4'h0;
        else
            cnt_reg <= cnt_reg + 4'h1;
    end

    assign tick = run && (cnt_reg == last_val);

endmodule
`default_nettype wire

// *** sarc_front.sv ***
/*
 Analog front end stand-in: returns the code the bench chose while
 converting, and range flags as plain levels.
 Assumes the bench sets code and flags before a conversion starts.
*/
`timescale 1ns/1ps
`default_nettype none

module sarc_front
(
    // Clock
    input  wire logic        pclk,
    // Device side
    input  wire logic        sample_run,
    // Bench control
    input  wire logic [11:0] code_in,
    input  wire logic        under_in,
    input  wire logic        over_in,
    // Toward the device
    output var  logic [11:0] sample_code,
    output wire logic        sample_under,
    output wire logic        sample_over
);
    initial sample_code = 12'h5A5;

    // Idle code keeps toggling so a stale value is never mistaken
    always @(posedge pclk)
    begin
        sample_code <= sample_run ? code_in : ~sample_code;
    end

    // Range flags are asynchronous levels
    assign sample_under = under_in;
    assign sample_over  = over_in;
endmodule

`default_nettype wire

// *** sarc_map.vh ***
/*
 Register map, field positions, reset values and timing counts of the
 successive-approximation converter control block.
 Assumes inclusion by bare name from the block's design files.
*/
`ifndef SARC_MAP_VH
`define SARC_MAP_VH

// ----------------------------------------------------------------------
// Register indexes; the APB byte address is four times the index
// ----------------------------------------------------------------------
`define SARC_IDX_REF        10'h0B0
`define SARC_IDX_MODE       10'h0B1
`define SARC_IDX_HIGH       10'h0B2
`define SARC_IDX_CTRL       10'h0B3
`define SARC_IDX_IRQ_STAT   10'h0B4
`define SARC_IDX_IRQ_EN     10'h0B5
`define SARC_IDX_IRQ_CLR    10'h0B6
`define SARC_ADDR_REF       {`SARC_IDX_REF, 2'b00}
`define SARC_ADDR_HIGH      {`SARC_IDX_HIGH, 2'b00}
`define SARC_ADDR_CTRL      {`SARC_IDX_CTRL, 2'b00}
`define SARC_ADDR_MODE      {`SARC_IDX_MODE, 2'b00}
`define SARC_ADDR_IRQ_STAT  {`SARC_IDX_IRQ_STAT, 2'b00}
`define SARC_ADDR_IRQ_EN    {`SARC_IDX_IRQ_EN, 2'b00}
`define SARC_ADDR_IRQ_CLR   {`SARC_IDX_IRQ_CLR, 2'b00}

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SARC_REF_EXT_BIT    7
`define SARC_CTRL_DIV1_BIT  6
`define SARC_CTRL_RES_BIT   5
`define SARC_CTRL_DIV0_BIT  4
`define SARC_MODE_START_BIT 6
`define SARC_MODE_DONE_BIT  5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SARC_REF_RESET      8'h00
`define SARC_CTRL_RESET     3'h0

// ----------------------------------------------------------------------
// Divider codes and timing counts
// ----------------------------------------------------------------------
`define SARC_DIV_CODE_16    2'h0
`define SARC_DIV_CODE_8     2'h1
`define SARC_DIV_CODE_1     2'h2
`define SARC_DIV_CODE_2     2'h3
`define SARC_QUARTERS_12B   16
`define SARC_QUARTERS_8B    12
`define SARC_QUARTER_TICKS  4
`define SARC_CYCLES_12B     (`SARC_QUARTERS_12B * `SARC_QUARTER_TICKS)
`define SARC_CYCLES_8B      (`SARC_QUARTERS_8B * `SARC_QUARTER_TICKS)

`endif

// *** sarc_props.sv ***
/*
 Port checker for the converter control block: reference outputs,
 conversion timing, setting hold and status read-back.
 Assumes it is bound to sarc_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module sarc_props
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Device outputs
    input wire logic        sample_run,
    input wire logic        sample_res12,
    input wire logic        ext_ref_select,
    input wire logic [1:0]  int_ref_level,
    input wire logic        shared_pin_free,
    input wire logic        irq
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    wire        acc = psel && penable;  // Access phase
    wire        wr  = acc && pwrite;    // Write taking effect
    logic [10:0] run_cnt;               // Cycles spent converting

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Counts converting cycles; cleared while idle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_cnt <= 11'h000;
        else if (sample_run)
            run_cnt <= run_cnt + 11'h001;
        else
            run_cnt <= 11'h000;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    ref_bit_a: assert property (
        wr && paddr == 12'h2C0 |=> ext_ref_select == $past(pwdata[7]))
        else $error("reference enable not applied");
    ref_level_a: assert property (
        wr && paddr == 12'h2C0 |=> int_ref_level == $past(pwdata[1:0]))
        else $error("reference level not applied");
    pin_free_a: assert property (
        shared_pin_free == !ext_ref_select)
        else $error("shared pin state wrong");
    start_run_a: assert property (
        wr && paddr == 12'h2C4 && pwdata[6] && !sample_run |=> sample_run)
        else $error("start did not begin conversion");
    res_hold_a: assert property (
        sample_run && $past(sample_run) |-> $stable(sample_res12))
        else $error("resolution changed mid conversion");
    conv_len_a: assert property (
        $fell(sample_run) |-> run_cnt inside {11'd48, 11'd96, 11'd384,
            11'd768, 11'd64, 11'd128, 11'd512, 11'd1024})
        else $error("conversion length illegal");
    busy_stat_a: assert property (
        acc && !pwrite && paddr == 12'h2C4 && sample_run
        |-> prdata[6:5] == 2'b10)
        else $error("busy status bits wrong");
    ref_read_a: assert property (
        acc && !pwrite && paddr == 12'h2C0
        |-> prdata[7] == ext_ref_select && prdata[1:0] == int_ref_level)
        else $error("reference read-back wrong");

    // Main scenarios reached
    cov_long: cover property ((sample_run && sample_res12) [*8]);
    cov_irq: cover property ($rose(irq));
    cov_ext: cover property ($rose(ext_ref_select));
endmodule

bind sarc_top sarc_props sarc_props_i
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .sample_run(sample_run), .sample_res12(sample_res12),
    .ext_ref_select(ext_ref_select), .int_ref_level(int_ref_level),
    .shared_pin_free(shared_pin_free), .irq(irq)
);

`default_nettype wire

// *** sarc_seq.v ***
/*
 Conversion sequencer: counts converter clock ticks and raises a
 one-cycle completion pulse after 48 or 64 ticks.
 Assumes tick is a one-cycle enable from the divider.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sarc_map.vh"

module sarc_seq
(
    // Clock and reset
    input  wire pclk,
    input  wire presetn,
    // Control
    input  wire busy,     // Conversion in progress
    input  wire res12,    // Latched resolution, 1 = 12-bit
    input  wire tick,     // Converter clock enable
    // Output
    output wire finish    // Last tick of the conversion
);

    // ------------------------------------------------------------------
    // Tick counter
    // ------------------------------------------------------------------
    localparam integer LAST_12_I = `SARC_CYCLES_12B - 1;
    localparam integer LAST_8_I  = `SARC_CYCLES_8B - 1;
    // Seven bits hold the longest count
    localparam [6:0] LAST_12 = LAST_12_I[6:0];
    localparam [6:0] LAST_8  = LAST_8_I[6:0];

    reg  [6:0] ticks_reg;        // Ticks seen so far
    wire [6:0] last_tick;        // Final tick index

    assign last_tick = res12 ? LAST_12 : LAST_8;

    // Cleared between conversions
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ticks_reg <= 7'h00;
        else if (!busy)
            ticks_reg <= 7'h00;
        else if (tick)
            ticks_reg <= ticks_reg + 7'h01;
    end

    assign finish = busy && tick && (ticks_reg == last_tick);

endmodule
`default_nettype wire

// *** sarc_top.v ***
/*
 Converter control: APB registers, reference selection, result buffer,
 conversion timing and a done interrupt.
 Assumes an analog front end that returns a 12-bit code on sample_code
 when the conversion ends, synchronous to pclk.
*/
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sarc_map.vh"

// Behaviour
// - Result is unsigned binary, n/4096 of reference
// - Low four result bits in control register
// - Result registers carry no reset value
// - External enable routes reference from shared pin
// - Otherwise internal reference, pin stays general
// - Level field picks supply, 4, 3, 2 V
// - Interval runs from start to done
// - Twelve-bit conversion takes 64 converter clocks
// - Eight-bit conversion takes 48 converter clocks
// - Converter clock is pclk over 1,2,8,16
// - Out-of-range input saturates to zero or full
// - Divider code 00/01/10/11 = 16/8/1/2
// - Resolution bit 0 eight-bit, 1 twelve-bit
// - End clears start bit and sets done
// - Eight-bit result lands in high byte
module sarc_top
(
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Analog front end
    input  wire [11:0] sample_code,     // Raw code from the array
    input  wire        sample_under,    // Input below low reference
    input  wire        sample_over,     // Input above high reference
    output wire        sample_run,      // Converter active
    output wire        sample_res12,    // Latched resolution
    // Reference selection
    output wire        ext_ref_select,  // Reference from shared pin
    output wire [1:0]  int_ref_level,   // Internal level code
    output wire        shared_pin_free, // Pin usable as GPIO/channel 0
    // Interrupt
    output wire        irq
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg        ext_ref_reg;        // External reference enable
    reg  [1:0] ref_level_reg;      // Internal reference level
    reg  [1:0] div_reg;            // Converter clock divider code
    reg        res_reg;            // Resolution select
    reg        start_reg;          // Conversion start / busy
    reg        done_reg;           // End of conversion flag
    reg  [1:0] div_lat_reg;        // Divider held for the conversion
    reg        res_lat_reg;        // Resolution held for the conversion
    reg  [7:0] high_reg;           // Result bits 11..4
    reg  [3:0] low_reg;            // Result bits 3..0
    reg        irq_stat_reg;       // Sticky done event
    reg        irq_en_reg;         // Interrupt enable
    reg  [1:0] under_s_reg;        // Synchroniser, under-range
    reg  [1:0] over_s_reg;         // Synchroniser, over-range

    // Reset images, sliced per field below
    localparam [7:0] REF_RESET  = `SARC_REF_RESET;
    localparam [2:0] CTRL_RESET = `SARC_CTRL_RESET;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire wr_en = psel && penable && pwrite;   // Write takes effect

    // Full match, low address bits included, so a byte offset
    // into a register counts as unmapped
    function addr_hit;
        input [11:0] addr;         // Bus address
        input [11:0] byte_addr;    // Register byte address
        begin
            addr_hit = (addr == byte_addr);
        end
    endfunction

    wire hit_ref  = addr_hit(paddr, `SARC_ADDR_REF);
    wire hit_high = addr_hit(paddr, `SARC_ADDR_HIGH);
    wire hit_ctrl = addr_hit(paddr, `SARC_ADDR_CTRL);
    wire hit_mode = addr_hit(paddr, `SARC_ADDR_MODE);
    wire hit_stat = addr_hit(paddr, `SARC_ADDR_IRQ_STAT);
    wire hit_en   = addr_hit(paddr, `SARC_ADDR_IRQ_EN);
    wire hit_clr  = addr_hit(paddr, `SARC_ADDR_IRQ_CLR);
    wire hit_any  = hit_ref | hit_high | hit_ctrl | hit_mode |
                    hit_stat | hit_en | hit_clr;

    // Zero wait state, unmapped access flagged as error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    wire start_wr = wr_en && hit_mode && !start_reg &&
                    pwdata[`SARC_MODE_START_BIT];

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    wire tick;                     // Converter clock enable
    wire finish;                   // Final converter tick

    sarc_clkdiv u_div
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .run      (start_reg),
        .div_code (div_lat_reg),
        .tick     (tick)
    );

    sarc_seq u_seq
    (
        .pclk    (pclk),
        .presetn (presetn),
        .busy    (start_reg),
        .res12   (res_lat_reg),
        .tick    (tick),
        .finish  (finish)
    );

    // ------------------------------------------------------------------
    // Range flag synchronisers
    // ------------------------------------------------------------------
    // Comparator flags are asynchronous to pclk
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            under_s_reg <= 2'h0;
            over_s_reg  <= 2'h0;
        end
        else
        begin
            under_s_reg <= {under_s_reg[0], sample_under};
            over_s_reg  <= {over_s_reg[0], sample_over};
        end
    end

    // ------------------------------------------------------------------
    // Result shaping
    // ------------------------------------------------------------------
    reg [11:0] result_next;        // Code to be captured at done

    // Saturate first, then mask the unused nibble in 8-bit mode
    always @*
    begin
        if (over_s_reg[1])
            result_next = 12'hFFF;
        else if (under_s_reg[1])
            result_next = 12'h000;
        else
            result_next = sample_code;
        if (!res_lat_reg)
            result_next = {result_next[11:4], 4'h0};
    end

    // ------------------------------------------------------------------
    // Result buffer, deliberately without reset
    // ------------------------------------------------------------------
    // Both halves load on the same edge as done
    always @(posedge pclk)
    begin
        if (finish)
        begin
            high_reg <= result_next[11:4];
            low_reg  <= result_next[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_ref_reg   <= REF_RESET[`SARC_REF_EXT_BIT];
            ref_level_reg <= REF_RESET[1:0];
            div_reg       <= CTRL_RESET[1:0];
            res_reg       <= CTRL_RESET[2];
            irq_en_reg    <= 1'b0;
        end
        else if (wr_en)
        begin
            if (hit_ref)
            begin
                ext_ref_reg   <= pwdata[`SARC_REF_EXT_BIT];
                ref_level_reg <= pwdata[1:0];
            end
            if (hit_ctrl)
            begin
                div_reg <= {pwdata[`SARC_CTRL_DIV1_BIT],
                            pwdata[`SARC_CTRL_DIV0_BIT]};
                res_reg <= pwdata[`SARC_CTRL_RES_BIT];
            end
            if (hit_en)
                irq_en_reg <= pwdata[0];
        end
    end

    // ------------------------------------------------------------------
    // Conversion control
    // ------------------------------------------------------------------
    // Start is ignored while busy; writes of 0 cannot abort
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_reg   <= 1'b0;
            done_reg    <= 1'b0;
            div_lat_reg <= 2'h0;
            res_lat_reg <= 1'b0;
        end
        else if (finish)
        begin
            start_reg <= 1'b0;
            done_reg  <= 1'b1;
        end
        else if (start_wr)
        begin
            start_reg   <= 1'b1;
            done_reg    <= 1'b0;
            div_lat_reg <= div_reg;
            res_lat_reg <= res_reg;
        end
        else if (wr_en && hit_mode && !pwdata[`SARC_MODE_DONE_BIT])
            done_reg <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Interrupt status: set wins over clear
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat_reg <= 1'b0;
        else if (finish)
            irq_stat_reg <= 1'b1;
        else if (wr_en && hit_clr && pwdata[0])
            irq_stat_reg <= 1'b0;
    end

    assign irq = irq_stat_reg && irq_en_reg;

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    reg [31:0] rd_word;            // Word selected by the address

    always @*
    begin
        rd_word = 32'h0000_0000;
        if (hit_ref)
            rd_word[7:0] = {ext_ref_reg, 5'h00, ref_level_reg};
        else if (hit_high)
            rd_word[7:0] = high_reg;
        else if (hit_ctrl)
            rd_word[7:0] = {1'b0, div_reg[1], res_reg, div_reg[0],
                            low_reg};
        else if (hit_mode)
            rd_word[7:0] = {1'b0, start_reg, done_reg, 5'h00};
        else if (hit_stat)
            rd_word[0] = irq_stat_reg;
        else if (hit_en)
            rd_word[0] = irq_en_reg;
    end

    // Read data captured in the setup phase; it then stands for the
    // whole access phase, at the cost of a one-cycle-old snapshot
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= rd_word;
    end

    // ------------------------------------------------------------------
    // Reference and front-end outputs
    // ------------------------------------------------------------------
    assign ext_ref_select  = ext_ref_reg;
    assign int_ref_level   = ref_level_reg;
    assign shared_pin_free = !ext_ref_reg;
    assign sample_run      = start_reg;
    assign sample_res12    = res_lat_reg;

endmodule
`default_nettype wire

// *** sarc_top_test.sv ***
/*
 Self-checking bench: reset-value reads, conversion table loop, then reference,
 unmapped, busy-restart, interrupt and mid-conversion reset tests.
 Assumes the front-end model; a register's byte address is four times
 its index.
*/
`timescale 1ns/1ps
`default_nettype none

module sarc_top_test;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0, code_in = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, under_in = 0, over_in = 0, er;
    logic [11:0] sample_code, ex;
    logic        sample_under, sample_over, sample_run, sample_res12;
    logic        ext_ref_select, shared_pin_free, irq;
    logic [1:0]  int_ref_level;
    logic [16:0] rows [6];   // {div, res, code, under, over}
    logic [16:0] rw;
    logic [7:0]  hi;         // High result byte of the current row
    int          miscompares = 0, tests_run = 0, cyc = 0, t0, i;

    always #12.5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    sarc_top sarc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_code(sample_code),
        .sample_under(sample_under), .sample_over(sample_over),
        .sample_run(sample_run), .sample_res12(sample_res12),
        .ext_ref_select(ext_ref_select), .int_ref_level(int_ref_level),
        .shared_pin_free(shared_pin_free), .irq(irq));
    sarc_front sarc_front_i (.pclk(pclk), .sample_run(sample_run),
        .code_in(code_in), .under_in(under_in), .over_in(over_in),
        .sample_code(sample_code), .sample_under(sample_under),
        .sample_over(sample_over));

    task test_done;
    begin
        if (miscompares == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    end
    endtask

    // One APB transfer; request held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
    begin
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1 && k < 50);
        if (pready !== 1) begin chk("pready", 1, 0); test_done; end
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
    end
    endtask

    // Wait for the converter to go idle; a hang ends the run
    task idle(input logic [31:0] n);
    begin
        while (sample_run !== 0 && cyc - t0 < 3000) @(posedge pclk) #1;
        if (sample_run !== 0) begin chk("idle", 0, 1); test_done; end
        chk("cycles", n, cyc - t0);
    end
    endtask

    // Start a conversion and wait for it to end
    task conv(input logic [31:0] n);
    begin
        apb(1, 12'h2C4, 32'h40); #1 t0 = cyc;
        idle(n);
    end
    endtask

    function int divr(input logic [1:0] c);
        divr = c == 2'h0 ? 16 : c == 2'h1 ? 8 : c == 2'h2 ? 1 : 2;
    endfunction

    initial
    begin
        rows = '{{2'h2, 1'b1, 12'h001, 2'b00}, {2'h3, 1'b0, 12'hABC, 2'b00},
                 {2'h1, 1'b1, 12'hFFE, 2'b00}, {2'h0, 1'b0, 12'h5A5, 2'b00},
                 {2'h2, 1'b1, 12'h123, 2'b01}, {2'h2, 1'b0, 12'h456, 2'b10}};
        repeat (20) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h2C0, 0); chk("ref", 0, rd);
        apb(0, 12'h2D0, 0); chk("stat", 0, rd);
        apb(0, 12'h2CC, 0); chk("ctrl", 0, rd & 32'hF0);
        for (i = 0; i < 6; i++)
        begin
            rw = rows[i];
            code_in <= rw[13:2]; under_in <= rw[1]; over_in <= rw[0];
            apb(1, 12'h2CC, {25'h0, rw[16], rw[14], rw[15], 4'h0});
            conv((rw[14] ? 64 : 48) * divr(rw[16:15]));
            ex = rw[0] ? 12'hFFF : rw[1] ? 12'h000 : rw[13:2];
            apb(0, 12'h2C8, 0); chk("high", ex[11:4], rd);
            hi = rd[7:0];
            apb(0, 12'h2CC, 0); chk("low", {rw[16], rw[14], rw[15],
                rw[14] ? ex[3:0] : 4'h0}, rd);
            if (rw[14]) chk("trunc10", ex[11:2], {hi, rd[3:2]});
            apb(0, 12'h2C4, 0); chk("mode", 32'h20, rd);
            apb(1, 12'h2C4, 0);
        end
        for (i = 0; i < 8; i++)
        begin
            apb(1, 12'h2C0, {i[2], 5'h0, i[1:0]}); #1;
            chk("ext", i[2], ext_ref_select);
            chk("free", !i[2], shared_pin_free);
            chk("level", i[1:0], int_ref_level);
        end
        apb(0, 12'h0A0, 0); chk("err", 1, er); chk("bad_rd", 0, rd);
        // Restart and new settings during a conversion are ignored
        apb(1, 12'h2D4, 1); code_in <= 12'h9C3; under_in <= 0; over_in <= 0;
        apb(1, 12'h2CC, 32'h60); apb(1, 12'h2C4, 32'h40); #1 t0 = cyc;
        apb(0, 12'h2C4, 0); chk("busy", 32'h40, rd);
        apb(1, 12'h2CC, 0); apb(1, 12'h2C4, 32'h40);
        #1 chk("res_held", 1, sample_res12);
        idle(64);
        apb(0, 12'h2CC, 0); chk("held", 32'h03, rd);
        chk("irq", 1, irq);
        apb(1, 12'h2D8, 1); #1 chk("irq_clr", 0, irq);
        // Masked event still sets status
        apb(1, 12'h2D4, 0); conv(768);
        chk("masked", 0, irq); apb(0, 12'h2D0, 0); chk("stat1", 1, rd);
        apb(1, 12'h2D4, 1); #1 chk("unmask", 1, irq);
        apb(1, 12'h2D8, 1); #1 chk("cleared", 0, irq);
        // Reset in mid-conversion: control back to idle, result kept
        apb(1, 12'h2C0, 32'h83); apb(1, 12'h2C4, 32'h40);
        repeat (5) @(posedge pclk);
        presetn <= 0; @(posedge pclk); presetn <= 1; #1;
        chk("run_rst", 0, sample_run); chk("irq_rst", 0, irq);
        chk("ext_rst", 0, ext_ref_select);
        chk("free_rst", 1, shared_pin_free);
        chk("lvl_rst", 0, int_ref_level);
        apb(0, 12'h2C4, 0); chk("mode_rst", 0, rd);
        apb(0, 12'h2C8, 0); chk("kept", 32'h9C, rd);
        test_done;
    end
endmodule

`default_nettype wire
